// ==== rtl/atc_regs.svh ====
/*
 * Register offsets, field positions, reset values and response codes of the
 * timer output-stage block.
 * Assumes inclusion by bare name from files under rtl/.
 */
`ifndef ATC_REGS_SVH
`define ATC_REGS_SVH
// ****************************************
// Register byte addresses
// ****************************************
`define ATC_OFF_CHCTRL   8'h00
`define ATC_OFF_COUNT    8'h04
`define ATC_OFF_SCALER   8'h08
`define ATC_OFF_PERIOD   8'h0c
`define ATC_OFF_REPEAT   8'h10
`define ATC_OFF_GATE     8'h14
`define ATC_OFF_CHMODE   8'h18
`define ATC_OFF_CMP1     8'h1c
`define ATC_OFF_CMP2     8'h20
`define ATC_OFF_CMP3     8'h24
`define ATC_OFF_CMP4     8'h28
`define ATC_OFF_STATUS   8'h2c
// ****************************************
// Field positions
// ****************************************
`define ATC_CH_STRIDE    4
`define ATC_CH4_EN_BIT   12
`define ATC_CH4_POL_BIT  13
`define ATC_CHCTRL_MASK  16'h3fff
`define ATC_GATE_MOUT    0
`define ATC_GATE_IDLE    1
`define ATC_GATE_RUN     2
`define ATC_GATE_IDLV    4
`define ATC_GATE_DT      8
`define ATC_DIR_W        2
`define ATC_DIR_OUTPUT   2'h0
// ****************************************
// Reset values and responses
// ****************************************
`define ATC_RST16        16'h0000
`define ATC_RST_GATE     32'h0000_0000
`define ATC_DT_RST       8'h01
`define ATC_RESP_OKAY    2'h0
`define ATC_RESP_SLVERR  2'h2
`endif

// ==== rtl/atc_pkg.sv ====
/*
 * Types shared by the timer output-stage files.
 * Assumes atc_regs.svh supplies the numeric constants.
 */
package atc_pkg;
  // Output-stage state shared by all channel pairs
  typedef enum logic [1:0] {
    ATC_ST_RUN   = 2'b00,
    ATC_ST_FORCE = 2'b01,
    ATC_ST_IDLE  = 2'b10
  } atc_stage_t;
  typedef logic [15:0] atc_word_t;
endpackage

// ==== rtl/atc_pair_if.sv ====
/*
 * Interface carrying one channel pair's controls and pin results.
 * Assumes the timer top drives the control side, the pair stage the rest.
 */
`timescale 1ns/1ns
`default_nettype none
interface atc_pair_if;
  logic mainEn;      // Channel enable
  logic mainPol;     // Main polarity
  logic compEn;      // Complementary enable
  logic compPol;     // Complementary polarity
  logic mainIdle;    // Main idle level
  logic compIdle;    // Complementary idle level
  logic rawCmp;      // Raw compare signal
  logic hasComp;     // Pair has a complementary output
  logic mainOut;     // Main output level
  logic mainOe;      // Main drive enable, high = driven
  logic compOut;     // Complementary output level
  logic compOe;      // Complementary drive enable
  modport ctrl (output mainEn, mainPol, compEn, compPol, mainIdle, compIdle,
    rawCmp, hasComp, input mainOut, mainOe, compOut, compOe);
  modport stage (input mainEn, mainPol, compEn, compPol, mainIdle, compIdle,
    rawCmp, hasComp, output mainOut, mainOe, compOut, compOe);
endinterface
`default_nettype wire

// ==== rtl/atc_pair_stage.sv ====
/*
 * Output stage of one channel pair: polarity, dead-time and off-states.
 * Assumes gate bits and dead-time come from the timer top on sys_clk.
 */
`timescale 1ns/1ns
`default_nettype none
`include "atc_regs.svh"
module atc_pair_stage #(
  parameter int DT_W = 8
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic masterOutGate,
  input wire logic offstateWhenIdle,
  input wire logic offstateWhenRunning,
  input wire logic [DT_W-1:0] deadTime,
  atc_pair_if.stage pr
);
  import atc_pkg::*;
  // ****************************************
  // Dead-time on rising edges of each leg
  // ****************************************
  logic [DT_W-1:0] dtCnt_ff;      // Cycles since raw signal edge
  logic [DT_W-1:0] nxt_dtCnt;
  logic rawDly_ff;                // Raw signal one cycle back
  logic [DT_W-1:0] idleCnt_ff;    // Cycles spent in forced state
  logic [DT_W-1:0] nxt_idleCnt;
  wire bothEn = pr.mainEn & pr.compEn & pr.hasComp;
  wire dtDone = (dtCnt_ff >= deadTime);
  wire idleDone = (idleCnt_ff >= deadTime);
  wire rawEdge = (pr.rawCmp != rawDly_ff);
  assign nxt_dtCnt = rawEdge ? '0 : (dtDone ? dtCnt_ff : dtCnt_ff + 1'b1);
  assign nxt_idleCnt = masterOutGate ? '0 : (idleDone ? idleCnt_ff : idleCnt_ff + 1'b1);
  // Edge tracker and counters
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dtCnt_ff <= '0;
      rawDly_ff <= 1'b0;
      idleCnt_ff <= '0;
    end else begin
      dtCnt_ff <= nxt_dtCnt;
      rawDly_ff <= pr.rawCmp;
      idleCnt_ff <= nxt_idleCnt;
    end
  end
  // Each leg turns on only after dead-time; turns off at once
  wire mainAct = pr.rawCmp & dtDone & ~rawEdge;
  wire compAct = ~pr.rawCmp & dtDone & ~rawEdge;
  wire mainRun = bothEn ? mainAct : pr.rawCmp;
  wire compRun = bothEn ? compAct : pr.rawCmp;
  // ****************************************
  // Output selection
  // ****************************************
  wire anyEn = pr.mainEn | (pr.compEn & pr.hasComp);
  // Gate cleared: float if idle off-state clear or both off, else inactive then idle levels
  wire idleDrive = offstateWhenIdle & anyEn;
  // Forced polarity first (combinational, no clock), idle after dead-time
  wire idleMain = idleDone ? pr.mainIdle : pr.mainPol;
  wire idleComp = idleDone ? pr.compIdle : pr.compPol;
  // Running: off-state when another output runs
  wire runMainOe = pr.mainEn | (offstateWhenRunning & pr.compEn & pr.hasComp);
  wire runCompOe = pr.hasComp & (pr.compEn | (offstateWhenRunning & pr.mainEn));
  // Main leg: disabled reads 0 or polarity, enabled is raw (dead-timed when both legs enabled) xor polarity
  wire runMain = pr.mainEn ? (mainRun ^ pr.mainPol) : (offstateWhenRunning & pr.mainPol);
  // Complementary leg with its own polarity and enable
  wire runComp = pr.compEn ? (compRun ^ pr.compPol) : (offstateWhenRunning & pr.compPol);
  assign pr.mainOut = masterOutGate ? runMain : (idleDrive & idleMain);
  assign pr.mainOe = masterOutGate ? runMainOe : idleDrive;
  assign pr.compOut = pr.hasComp & (masterOutGate ? runComp : (idleDrive & idleComp));
  assign pr.compOe = pr.hasComp & (masterOutGate ? runCompOe : idleDrive);
  // ****************************************
  // Checks
  // ****************************************
  a_lone_main_xor: assert property (@(posedge sys_clk) disable iff (!arst_n)
    masterOutGate && pr.mainEn && !bothEn |-> pr.mainOut == (pr.rawCmp ^ pr.mainPol))
    else $error("lone main output not raw xor polarity");
  a_disabled_zero: assert property (@(posedge sys_clk) disable iff (!arst_n)
    masterOutGate && !offstateWhenRunning && !pr.mainEn |-> !pr.mainOe && !pr.mainOut)
    else $error("disabled main output driven");
  a_offstate_run: assert property (@(posedge sys_clk) disable iff (!arst_n)
    masterOutGate && offstateWhenRunning && !pr.mainEn && pr.compEn && pr.hasComp
    |-> pr.mainOe && pr.mainOut == pr.mainPol)
    else $error("main off-state level wrong");
  a_idle_float: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !masterOutGate && (!offstateWhenIdle || !anyEn) |-> !pr.mainOe && !pr.compOe)
    else $error("idle outputs driven");
  sequence s_gateDrop;
    $fell(masterOutGate) && offstateWhenIdle && anyEn;
  endsequence
  a_idle_force: assert property (@(posedge sys_clk) disable iff (!arst_n)
    s_gateDrop |-> pr.mainOe && pr.mainOut == pr.mainPol)
    else $error("idle entry not at polarity");
  a_no_overlap: assert property (@(posedge sys_clk) disable iff (!arst_n)
    masterOutGate && bothEn |-> !(mainAct && compAct))
    else $error("both legs active together");
endmodule
`default_nettype wire

// ==== rtl/atc_timer_out.sv ====
/*
 * Advanced timer time base and channel output control, AXI4-Lite slave.
 * Assumes a single 25 MHz sys_clk, synchronous inputs, and pad logic outside
 * that turns each output and enable into a pin drive.
 */
// Summary of operation
// - Main polarity picks active-high or active-low output
// - Input mode: polarity picks edge and trigger inversion
// - Complementary polarity picks complementary active level
// - Complementary enable switches complementary output
// - Channel enable switches input or output
// - Channels 2,3 same bits; channel 4 enable/polarity
// - Gate on, running off-state clear: disabled undriven
// - Lone output raw xor polarity; pair dead-timed
// - Running off-state: disabled output drives polarity level while its partner is enabled
// - Gate off, idle off-state clear: outputs float
// - Gate off, idle off-state set: inactive unless both off
// - Idle: polarity first, idle levels after dead-time
// - Counter rate is clock over divider plus one
// - Divider write buffered, loaded on overflow
// - Period sets counter period; zero stops counter
// - Repetition counter thins overflows, event at zero
// - Direction 00 is output, else input
// - Output compares data; input captures counter
`timescale 1ns/1ns
`default_nettype none
`include "atc_regs.svh"
module atc_timer_out #(
  parameter int CNT_W = 16,
  parameter int DT_W = 8
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] chInput,
  output logic [3:0] mainOutput,
  output logic [3:0] mainOutOe,
  output logic [2:0] compOutput,
  output logic [2:0] compOutOe,
  output logic [3:0] extTrigger,
  output logic overflowPulse,
  output atc_pkg::atc_stage_t stageState
);
  import atc_pkg::*;
  // ****************************************
  // Registers
  // ****************************************
  logic [15:0] chCtrl_ff;          // Channel enables and polarities
  logic [CNT_W-1:0] count_ff;      // Running count
  logic [CNT_W-1:0] scaler_ff;     // Divider buffer written by software
  logic [CNT_W-1:0] scalerAct_ff;  // Working prescaler
  logic [CNT_W-1:0] preCnt_ff;     // Prescaler tick counter
  logic [CNT_W-1:0] period_ff;     // Period limit
  logic [CNT_W-1:0] repeat_ff;     // Repetition reload
  logic [CNT_W-1:0] repCnt_ff;     // Repetition down-counter
  logic [31:0] gate_ff;            // Gate, off-state, idle, dead-time
  logic [7:0] chMode_ff;           // Two direction bits per channel
  logic [CNT_W-1:0] cmp_ff [4];    // Compare or capture data
  logic [3:0] inDly_ff;            // Previous input samples
  logic overflow_ff;               // Registered overflow event
  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  logic awHeld_ff, wHeld_ff, bvalid_ff;
  logic [7:0] awAddr_ff;
  logic [31:0] wData_ff;
  logic [3:0] wStrb_ff;
  // Accept each half once, hold until the response is gone
  assign s_axi_awready = !awHeld_ff && !bvalid_ff;
  assign s_axi_wready = !wHeld_ff && !bvalid_ff;
  wire wrFire = awHeld_ff && wHeld_ff && !bvalid_ff;
  wire [31:0] wBits = {{8{wStrb_ff[3]}}, {8{wStrb_ff[2]}}, {8{wStrb_ff[1]}}, {8{wStrb_ff[0]}}};
  wire [7:0] wIdx = awAddr_ff;
  wire wrMapped = (wIdx <= `ATC_OFF_STATUS) && (wIdx[1:0] == 2'b00) && (wIdx != `ATC_OFF_STATUS);
  // Merge new bytes into an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction
  wire wrCh = wrFire && wIdx == `ATC_OFF_CHCTRL;
  wire wrCnt = wrFire && wIdx == `ATC_OFF_COUNT;
  wire wrScl = wrFire && wIdx == `ATC_OFF_SCALER;
  wire wrPer = wrFire && wIdx == `ATC_OFF_PERIOD;
  wire wrRep = wrFire && wIdx == `ATC_OFF_REPEAT;
  wire wrGate = wrFire && wIdx == `ATC_OFF_GATE;
  wire wrMode = wrFire && wIdx == `ATC_OFF_CHMODE;
  // Handshake bookkeeping
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      awHeld_ff <= 1'b0;
      wHeld_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      awAddr_ff <= 8'h00;
      wData_ff <= 32'h0000_0000;
      wStrb_ff <= 4'h0;
      s_axi_bresp <= `ATC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end
      if (wrFire) begin
        awHeld_ff <= 1'b0;
        wHeld_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        s_axi_bresp <= wrMapped ? `ATC_RESP_OKAY : `ATC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_ff;
  // ****************************************
  // Time base
  // ****************************************
  wire running = (period_ff != '0);
  wire preTick = running && (preCnt_ff >= scalerAct_ff);
  wire wrap = preTick && (count_ff >= period_ff);
  wire repZero = (repCnt_ff == '0);
  wire overflowEv = wrap && repZero;
  wire [CNT_W-1:0] nxt_count = wrap ? '0 : (preTick ? count_ff + 1'b1 : count_ff);
  // Prescaler, counter and repetition counter
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_ff <= `ATC_RST16;
      preCnt_ff <= `ATC_RST16;
      scalerAct_ff <= `ATC_RST16;
      repCnt_ff <= `ATC_RST16;
      overflow_ff <= 1'b0;
    end else begin
      preCnt_ff <= (!running || preTick) ? '0 : preCnt_ff + 1'b1;
      // Software write replaces the running count
      count_ff <= wrCnt ? 16'(merge({16'h0000, count_ff}, wData_ff, wBits)) : nxt_count;
      if (overflowEv) begin
        scalerAct_ff <= scaler_ff;
        repCnt_ff <= repeat_ff;
      end else if (wrap) begin
        repCnt_ff <= repCnt_ff - 1'b1;
      end
      overflow_ff <= overflowEv;
    end
  end
  assign overflowPulse = overflow_ff;
  // ****************************************
  // Software registers
  // ****************************************
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      chCtrl_ff <= `ATC_RST16;
      scaler_ff <= `ATC_RST16;
      period_ff <= `ATC_RST16;
      repeat_ff <= `ATC_RST16;
      gate_ff <= `ATC_RST_GATE | ({24'h0, `ATC_DT_RST} << `ATC_GATE_DT);
      chMode_ff <= 8'h00;
    end else begin
      // Reserved bits 15:14 stay zero
      if (wrCh) chCtrl_ff <= 16'(merge({16'h0, chCtrl_ff}, wData_ff, wBits)) & `ATC_CHCTRL_MASK;
      if (wrScl) scaler_ff <= 16'(merge({16'h0, scaler_ff}, wData_ff, wBits));
      if (wrPer) period_ff <= 16'(merge({16'h0, period_ff}, wData_ff, wBits));
      if (wrRep) repeat_ff <= 16'(merge({16'h0, repeat_ff}, wData_ff, wBits));
      if (wrGate) gate_ff <= merge(gate_ff, wData_ff, wBits);
      if (wrMode) chMode_ff <= 8'(merge({24'h0, chMode_ff}, wData_ff, wBits));
    end
  end
  // ****************************************
  // Channels: compare, capture, triggers
  // ****************************************
  logic [3:0] isOutput, rawCmp, capEdge;
  genvar gi;
  for (gi = 0; gi < 4; gi++) begin : g_ch
    wire wrCmp = wrFire && wIdx == (`ATC_OFF_CMP1 + 8'(4 * gi));
    wire chEn = chCtrl_ff[gi * `ATC_CH_STRIDE];
    wire chPol = chCtrl_ff[gi * `ATC_CH_STRIDE + 1];
    // Direction 00 means output
    assign isOutput[gi] = chMode_ff[gi*2 +: `ATC_DIR_W] == `ATC_DIR_OUTPUT;
    // Raw compare: high while count below data
    assign rawCmp[gi] = isOutput[gi] && (count_ff < cmp_ff[gi]);
    // Polarity picks rising or falling edge; trigger inverted
    assign capEdge[gi] = chPol ? (inDly_ff[gi] & ~chInput[gi]) : (~inDly_ff[gi] & chInput[gi]);
    assign extTrigger[gi] = chInput[gi] ^ chPol;
    // Capture needs enabled input channel
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        cmp_ff[gi] <= `ATC_RST16;
      end else if (wrCmp) begin
        cmp_ff[gi] <= 16'(merge({16'h0, cmp_ff[gi]}, wData_ff, wBits));
      end else if (!isOutput[gi] && chEn && capEdge[gi]) begin
        cmp_ff[gi] <= count_ff;
      end
    end
  end
  // Input history for edge detect
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) inDly_ff <= 4'h0;
    else inDly_ff <= chInput;
  end
  // ****************************************
  // Output stages
  // ****************************************
  wire gateOn = gate_ff[`ATC_GATE_MOUT];
  atc_pair_if pairIf [4] ();
  for (gi = 0; gi < 4; gi++) begin : g_pair
    // Pair bits sit at stride four; channel 4 lacks complement
    assign pairIf[gi].mainEn = chCtrl_ff[gi * `ATC_CH_STRIDE] & isOutput[gi];
    assign pairIf[gi].mainPol = chCtrl_ff[gi * `ATC_CH_STRIDE + 1];
    assign pairIf[gi].compEn = (gi < 3) ? chCtrl_ff[gi * `ATC_CH_STRIDE + 2] : 1'b0;
    assign pairIf[gi].compPol = (gi < 3) ? chCtrl_ff[gi * `ATC_CH_STRIDE + 3] : 1'b0;
    assign pairIf[gi].mainIdle = gate_ff[`ATC_GATE_IDLV + gi * 2];
    assign pairIf[gi].compIdle = gate_ff[`ATC_GATE_IDLV + gi * 2 + 1];
    assign pairIf[gi].rawCmp = rawCmp[gi];
    assign pairIf[gi].hasComp = (gi < 3);
    atc_pair_stage #(.DT_W(DT_W)) u_stage (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .masterOutGate(gateOn),
      .offstateWhenIdle(gate_ff[`ATC_GATE_IDLE]),
      .offstateWhenRunning(gate_ff[`ATC_GATE_RUN]),
      .deadTime(gate_ff[`ATC_GATE_DT +: DT_W]),
      .pr(pairIf[gi])
    );
    assign mainOutput[gi] = pairIf[gi].mainOut;
    assign mainOutOe[gi] = pairIf[gi].mainOe;
    if (gi < 3) begin : g_comp
      assign compOutput[gi] = pairIf[gi].compOut;
      assign compOutOe[gi] = pairIf[gi].compOe;
    end
  end
  // Summary state of the stage
  assign stageState = gateOn ? ATC_ST_RUN : (gate_ff[`ATC_GATE_IDLE] ? ATC_ST_IDLE : ATC_ST_FORCE);
  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  logic rvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  wire [7:0] rIdx = s_axi_araddr;
  wire [31:0] statusWord = {12'h0, overflow_ff, running, stageState, isOutput, 12'h0};
  wire [31:0] rdMux =
    (rIdx == `ATC_OFF_CHCTRL) ? {16'h0, chCtrl_ff} :
    (rIdx == `ATC_OFF_COUNT)  ? {16'h0, count_ff} :
    (rIdx == `ATC_OFF_SCALER) ? {16'h0, scaler_ff} :
    (rIdx == `ATC_OFF_PERIOD) ? {16'h0, period_ff} :
    (rIdx == `ATC_OFF_REPEAT) ? {16'h0, repeat_ff} :
    (rIdx == `ATC_OFF_GATE)   ? gate_ff :
    (rIdx == `ATC_OFF_CHMODE) ? {24'h0, chMode_ff} :
    (rIdx == `ATC_OFF_CMP1)   ? {16'h0, cmp_ff[0]} :
    (rIdx == `ATC_OFF_CMP2)   ? {16'h0, cmp_ff[1]} :
    (rIdx == `ATC_OFF_CMP3)   ? {16'h0, cmp_ff[2]} :
    (rIdx == `ATC_OFF_CMP4)   ? {16'h0, cmp_ff[3]} :
    (rIdx == `ATC_OFF_STATUS) ? statusWord : 32'h0000_0000;
  wire rdMapped = (rIdx <= `ATC_OFF_STATUS) && (rIdx[1:0] == 2'b00);
  // One read in flight
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rvalid_ff <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `ATC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      s_axi_rdata <= rdMapped ? rdMux : 32'h0000_0000;
      s_axi_rresp <= rdMapped ? `ATC_RESP_OKAY : `ATC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_ff;
  // ****************************************
  // Checks
  // ****************************************
  a_period_stop: assert property (@(posedge sys_clk) disable iff (!arst_n)
    period_ff == '0 && !wrCnt |=> $stable(count_ff))
    else $error("counter moved with zero period");
  a_scaler_load: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $changed(scalerAct_ff) |-> $past(overflowEv))
    else $error("prescaler loaded without overflow");
  a_rep_reload: assert property (@(posedge sys_clk) disable iff (!arst_n)
    overflowEv |=> repCnt_ff == $past(repeat_ff) && overflow_ff)
    else $error("repetition not reloaded");
  a_rep_thin: assert property (@(posedge sys_clk) disable iff (!arst_n)
    wrap && !repZero |=> !overflow_ff)
    else $error("overflow before repetition zero");
  a_count_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
    wrCnt && wStrb_ff == 4'hf |=> count_ff == $past(wData_ff[15:0]))
    else $error("counter write lost");
  a_input_nodrive: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !isOutput[0] && gateOn && !gate_ff[`ATC_GATE_RUN] && !chCtrl_ff[2] |-> !mainOutOe[0])
    else $error("input channel drives pin");
endmodule
`default_nettype wire

// ==== tb/atc_pin_model.sv ====
/* Far-side model: gate pins with pull-downs fed by drive and enable.
   Assumes enable high means the timer drives the pin. */
`timescale 1ns/1ns
`default_nettype none
module atc_pin_model #(parameter int W = 4) (
  input wire logic [W-1:0] drive,
  input wire logic [W-1:0] oe,
  output logic [W-1:0] pinLvl
);
  // Undriven gate falls to its pull-down, so a float never reads stale
  assign pinLvl = drive & oe;
endmodule
`default_nettype wire

// ==== tb/atc_timer_out_test.sv ====
/* Self-checking bench of the timer output block over AXI4-Lite.
   Assumes the byte map of atc_regs.svh and one 25 MHz clock. */
`timescale 1ns/1ns
`default_nettype none
`include "atc_regs.svh"
module atc_timer_out_test;
  import atc_pkg::*;
  logic sys_clk = 0, arst_n = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf, chInput = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, lastResp;
  logic [3:0] mainOutput, mainOutOe, extTrigger, mainPin;
  logic [2:0] compOutput, compOutOe, compPin;
  logic overflowPulse, pa, pw;
  atc_stage_t stageState;
  int failures = 0, total_checks = 0, n;
  atc_timer_out dut (.*);
  atc_pin_model #(.W(4)) mPins (.drive(mainOutput), .oe(mainOutOe), .pinLvl(mainPin));
  atc_pin_model #(.W(3)) cPins (.drive(compOutput), .oe(compOutOe), .pinLvl(compPin));
  // 40 ns clock
  initial forever #20 sys_clk = ~sys_clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Write: address and data offered together, each dropped when taken
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    pa = 1;
    pw = 1;
    while (pa || pw) begin
      @(posedge sys_clk);
      if (pa && s_axi_awready) begin
        pa = 0;
        s_axi_awvalid <= 0;
      end
      if (pw && s_axi_wready) begin
        pw = 0;
        s_axi_wvalid <= 0;
      end
    end
    do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
    lastResp = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic axiRd(input logic [7:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    lastResp = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  // Outputs are combinational from registers; let writes land first
  task automatic settle;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  // Count overflow pulses over 80 cycles once the new setting took hold
  task automatic cntOvf;
    repeat (20) @(posedge sys_clk);
    n = 0;
    repeat (80) begin
      @(posedge sys_clk);
      if (overflowPulse === 1'b1) n++;
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge sys_clk);
    arst_n <= 1;
    for (int a = 0; a < 5; a++) begin
      axiRd(8'(a * 4));
      chk(rd, 0);
    end
    axiRd(8'h30);
    chk(lastResp, `ATC_RESP_SLVERR);
    axiWr(`ATC_OFF_CHCTRL, 32'hffff);
    chk(lastResp, `ATC_RESP_OKAY);
    axiRd(`ATC_OFF_CHCTRL);
    chk(rd, 32'h3fff);
    axiWr(`ATC_OFF_GATE, 32'h101);
    axiWr(`ATC_OFF_CHCTRL, 32'h3); // Unused pairs kept clear
    settle;
    chk({mainPin[0], mainOutOe[0], compOutOe[0]}, 3'b110);
    axiWr(`ATC_OFF_CHCTRL, 32'hc);
    settle;
    chk({compPin[0], compOutOe[0], mainOutOe[0], mainOutput[0]}, 4'hc);
    axiWr(`ATC_OFF_GATE, 32'h105);
    settle;
    chk({mainOutOe[0], mainOutput[0]}, 2'b10);
    // Main polarity high: off-state must drive the inactive level one
    axiWr(`ATC_OFF_CHCTRL, 32'he);
    settle;
    chk({mainOutOe[0], mainPin[0]}, 2'b11);
    // Both legs enabled, raw low: main inactive, complement active
    axiWr(`ATC_OFF_CHCTRL, 32'h5);
    settle;
    chk({mainPin[0], compPin[0], mainOutOe[0], compOutOe[0]}, 4'h7);
    axiWr(`ATC_OFF_GATE, 32'h100);
    settle;
    chk({mainPin[0], mainOutOe[0], compOutOe[0], stageState}, {3'b000, ATC_ST_FORCE});
    axiWr(`ATC_OFF_CHCTRL, 32'h3);
    axiWr(`ATC_OFF_GATE, 32'h102);
    settle;
    chk({mainOutOe[0], mainOutput[0], compOutOe[0], stageState}, {3'b101, ATC_ST_IDLE});
    // Gate drop with a long dead-time: polarity level first, idle level later
    axiWr(`ATC_OFF_GATE, 32'h1003);
    axiWr(`ATC_OFF_GATE, 32'h1002);
    #1;
    chk({mainOutOe[0], mainOutput[0]}, 2'b11);
    repeat (20) @(posedge sys_clk);
    #1;
    chk({mainOutOe[0], mainOutput[0]}, 2'b10);
    axiWr(`ATC_OFF_CHCTRL, 32'h0);
    settle;
    chk({mainOutOe[0], compOutOe[0]}, 2'b00);
    axiWr(`ATC_OFF_CHMODE, 32'h1);
    axiWr(`ATC_OFF_CHCTRL, 32'h3);
    @(posedge sys_clk);
    chInput <= 4'h1;
    settle;
    chk(extTrigger[0], 1'b0);
    axiWr(`ATC_OFF_PERIOD, 32'h3);
    axiWr(`ATC_OFF_REPEAT, 32'h1);
    cntOvf;
    chk(n, 10);
    // Running, idle stage, channel 1 input, others output; overflow bit masked
    axiRd(`ATC_OFF_STATUS);
    chk(rd & 32'hfff7_ffff, 32'h0006_e000);
    axiWr(`ATC_OFF_REPEAT, 32'h0);
    axiWr(`ATC_OFF_SCALER, 32'h1);
    cntOvf;
    chk(n, 10);
    axiWr(`ATC_OFF_PERIOD, 32'h0);
    axiWr(`ATC_OFF_COUNT, 32'h5);
    repeat (4) @(posedge sys_clk);
    axiRd(`ATC_OFF_COUNT);
    chk(rd, 32'h5);
    // Falling input edge with polarity one captures the stopped count
    chInput <= 4'h0;
    axiRd(`ATC_OFF_CMP1);
    chk(rd, 32'h5);
    print_verdict;
  end
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    print_verdict;
  end
endmodule
`default_nettype wire
